/* core/mcd_avg.sv */
// sliding mean of position error and velocity over a power-of-two span
`timescale 1ns/100ps
module mcd_avg #(
   parameter int W = 32,
   parameter int LMAX = 4
) (
   input wire logic i_clk,
   input wire logic i_rst,
   mcd_avg_if.avg a
);
   localparam int D = 1 << LMAX;
   localparam int SW = W + LMAX;
   logic [LMAX-1:0] wr_idx;
   logic [LMAX:0] fill;
   logic [LMAX:0] span;
   logic [LMAX-1:0] old_idx;
   logic signed [W-1:0] smp [2];
   logic signed [W-1:0] mean [2];

   if (LMAX < 1 || LMAX > 7) begin : g_bad
      $error("mcd_avg: LMAX out of range");
   end

   // ------------------------------------------------------------
   // window bookkeeping
   // ------------------------------------------------------------
   assign span = (LMAX+1)'(1) << a.span_log2;
   assign old_idx = wr_idx - span[LMAX-1:0];
   assign a.full = (fill >= span);
   assign smp[0] = a.err_in;
   assign smp[1] = a.vel_in;

   always_ff @(posedge i_clk) begin
      if (i_rst || a.clear) begin
         wr_idx <= '0;
         fill <= '0;
      end else if (a.valid) begin
         wr_idx <= wr_idx + 1'b1;
         if (fill != (LMAX+1)'(D)) begin
            fill <= fill + 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // one running sum per channel, oldest sample dropped once full
   // ------------------------------------------------------------
   for (genvar c = 0; c < 2; c++) begin : g_ch
      logic signed [W-1:0] hist [D];
      logic signed [SW-1:0] sum;
      logic signed [SW-1:0] drop;
      assign drop = a.full ? SW'(hist[old_idx]) : '0;
      assign mean[c] = W'(sum >>> a.span_log2);
      always_ff @(posedge i_clk) begin
         if (i_rst || a.clear) begin
            sum <= '0;
         end else if (a.valid) begin
            sum <= sum + SW'(smp[c]) - drop;
         end
      end
      always_ff @(posedge i_clk) begin
         if (a.valid) begin
            hist[wr_idx] <= smp[c];
         end
      end
   end

   assign a.err_mean = mean[0];
   assign a.vel_mean = mean[1];

   AST_AVG_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst)
      a.clear |=> !a.full)
      else $error("mean reported valid right after clear");
endmodule

/* core/mcd_avg_if.sv */
// carrier between the detector and its sliding mean filter
`timescale 1ns/100ps
interface mcd_avg_if #(
   parameter int W = 32,
   parameter int SW = 3
);
   logic clear;
   logic valid;
   logic signed [W-1:0] err_in;
   logic signed [W-1:0] vel_in;
   logic [SW-1:0] span_log2;
   logic signed [W-1:0] err_mean;
   logic signed [W-1:0] vel_mean;
   logic full;
   modport ctl (output clear, valid, err_in, vel_in, span_log2, input err_mean, vel_mean, full);
   modport avg (input clear, valid, err_in, vel_in, span_log2, output err_mean, vel_mean, full);
endinterface

/* core/mcd_pkg.sv */
// constants and types shared by the motion completion detector
package mcd_pkg;
   localparam int POS_W = 32;
   localparam int CNT_W = 32;
   localparam int SPAN_W = 3;
   localparam int SPAN_LOG2_MAX = 4;
   localparam int N_COORD = 6;
   localparam int QIDX_W = 4;
   localparam logic METHOD_PROFILER = 1'b0;
   localparam logic METHOD_WINDOWED = 1'b1;
   localparam logic [POS_W-1:0] POS_RST = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
   localparam logic [QIDX_W-1:0] QIDX_STRUT = 4'h6;
   localparam logic [QIDX_W-1:0] QIDX_END = 4'hc;
   localparam logic [2:0] QCNT_ALL = 3'h6;
   localparam logic [2:0] QCNT_ONE = 3'h1;
   localparam logic [2:0] QCNT_NONE = 3'h0;
   typedef enum logic [2:0] {
      ST_READY = 3'b001,
      ST_PROFILE = 3'b010,
      ST_SETTLE = 3'b100
   } mcd_state_t;
endpackage

/* core/mcd_top.sv */
// motion completion detector: profiler, position bookkeeping and settle check
`timescale 1ns/100ps
module mcd_top #(
   parameter int LMAX = mcd_pkg::SPAN_LOG2_MAX
) (
   input wire logic I_REF_CLK,
   input wire logic I_RST,
   input wire logic I_CFG_METHOD,
   input wire logic [mcd_pkg::POS_W-1:0] I_CFG_POS_WIN,
   input wire logic [mcd_pkg::POS_W-1:0] I_CFG_VEL_WIN,
   input wire logic [mcd_pkg::CNT_W-1:0] I_CFG_HOLD,
   input wire logic [mcd_pkg::SPAN_W-1:0] I_CFG_SPAN,
   input wire logic [mcd_pkg::CNT_W-1:0] I_CFG_TIMEOUT,
   input wire logic I_PARAM_RD,
   input wire logic I_PARAM_WR,
   input wire logic [mcd_pkg::POS_W-1:0] I_WR_POS_WIN,
   input wire logic [mcd_pkg::POS_W-1:0] I_WR_VEL_WIN,
   input wire logic [mcd_pkg::CNT_W-1:0] I_WR_HOLD,
   input wire logic [mcd_pkg::SPAN_W-1:0] I_WR_SPAN,
   input wire logic [mcd_pkg::CNT_W-1:0] I_WR_TIMEOUT,
   input wire logic I_GROUP_READY,
   input wire logic I_MOVE_START,
   input wire logic signed [mcd_pkg::POS_W-1:0] I_MOVE_TARGET,
   input wire logic [mcd_pkg::POS_W-1:0] I_MOVE_STEP,
   input wire logic I_SAMPLE,
   input wire logic signed [mcd_pkg::POS_W-1:0] I_ENC_POS,
   input wire logic signed [mcd_pkg::POS_W-1:0] I_COMP_BACKLASH,
   input wire logic signed [mcd_pkg::POS_W-1:0] I_COMP_LINEAR,
   input wire logic signed [mcd_pkg::POS_W-1:0] I_COMP_HYST,
   input wire logic signed [mcd_pkg::POS_W-1:0] I_COMP_MAP,
   input wire logic signed [mcd_pkg::POS_W-1:0] I_VELOCITY,
   input wire logic I_QUERY,
   input wire logic I_QUERY_ALL,
   input wire logic [mcd_pkg::QIDX_W-1:0] I_QUERY_IDX,
   input wire logic [mcd_pkg::N_COORD*mcd_pkg::POS_W-1:0] I_PLAT_COORDS,
   input wire logic [mcd_pkg::N_COORD*mcd_pkg::POS_W-1:0] I_STRUT_LENS,
   output logic O_METHOD,
   output logic O_READY,
   output logic O_MOVE_REFUSED,
   output logic O_PROFILE_END,
   output logic O_MOTION_COMPLETE,
   output logic O_SETTLE_TIMEOUT,
   output logic signed [mcd_pkg::POS_W-1:0] O_MEASURED_POS,
   output logic signed [mcd_pkg::POS_W-1:0] O_COMMANDED_POS,
   output logic signed [mcd_pkg::POS_W-1:0] O_TRACKING_ERROR,
   output logic signed [mcd_pkg::POS_W-1:0] O_DESTINATION_POS,
   output logic O_PARAM_ACK,
   output logic [mcd_pkg::POS_W-1:0] O_PARAM_POS_WIN,
   output logic [mcd_pkg::POS_W-1:0] O_PARAM_VEL_WIN,
   output logic [mcd_pkg::CNT_W-1:0] O_PARAM_HOLD,
   output logic [mcd_pkg::SPAN_W-1:0] O_PARAM_SPAN,
   output logic [mcd_pkg::CNT_W-1:0] O_PARAM_TIMEOUT,
   output logic O_QUERY_VALID,
   output logic [2:0] O_QUERY_COUNT,
   output logic [mcd_pkg::N_COORD*mcd_pkg::POS_W-1:0] O_QUERY_DATA
);
   localparam int W = mcd_pkg::POS_W;
   localparam int CW = mcd_pkg::CNT_W;
   localparam int SW = mcd_pkg::SPAN_W;
   localparam int QW = mcd_pkg::N_COORD * W;
   default clocking cb @(posedge I_REF_CLK);
   endclocking
   default disable iff (I_RST);

   if (LMAX < 1 || LMAX >= (1 << SW)) begin : g_bad
      $error("mcd_top: LMAX out of range");
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [W-1:0] absv(input logic signed [W-1:0] v);
      return v[W-1] ? W'(-v) : W'(v);
   endfunction

   function automatic logic [SW-1:0] clamp_span(input logic [SW-1:0] v);
      return (v > SW'(LMAX)) ? SW'(LMAX) : v;
   endfunction

   function automatic logic [W-1:0] pick(input logic [QW-1:0] vec, input logic [mcd_pkg::QIDX_W-1:0] idx);
      return vec[idx*W +: W];
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   mcd_pkg::mcd_state_t state;
   mcd_pkg::mcd_state_t next_state;
   logic method;
   logic [W-1:0] pos_win;
   logic [W-1:0] vel_win;
   logic [CW-1:0] hold_lim;
   logic [SW-1:0] span;
   logic [CW-1:0] tmo_lim;
   logic [SW-1:0] span_mv;
   logic [W-1:0] step_mv;
   logic [CW-1:0] hold_cnt;
   logic [CW-1:0] tmo_cnt;

   mcd_avg_if #(.W(W), .SW(SW)) avg_bus ();

   mcd_avg #(
      .W(W),
      .LMAX(LMAX)
   ) u_avg (
      .i_clk(I_REF_CLK),
      .i_rst(I_RST),
      .a(avg_bus)
   );

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire logic is_ready = (state == mcd_pkg::ST_READY);
   wire logic is_prof = (state == mcd_pkg::ST_PROFILE);
   wire logic is_settle = (state == mcd_pkg::ST_SETTLE);
   wire logic start_ok = I_MOVE_START && is_ready && I_GROUP_READY;
   wire logic start_bad = I_MOVE_START && !start_ok;
   wire logic signed [W-1:0] remaining = O_DESTINATION_POS - O_COMMANDED_POS;
   wire logic last_step = (step_mv == '0) || (absv(remaining) <= step_mv);
   wire logic prof_fin = is_prof && I_SAMPLE && last_step;
   wire logic pos_ok = absv(avg_bus.err_mean) < pos_win;
   wire logic vel_ok = absv(avg_bus.vel_mean) < vel_win;
   wire logic win_ok = avg_bus.full && pos_ok && vel_ok;
   wire logic [CW-1:0] hold_next = hold_cnt + 1'b1;
   wire logic hold_done = is_settle && win_ok && (hold_next >= hold_lim);
   wire logic tmo_hit = is_settle && !hold_done && (tmo_cnt >= tmo_lim);
   wire logic prof_done = prof_fin && (method == mcd_pkg::METHOD_PROFILER);
   wire logic complete = prof_done || hold_done;
   wire logic signed [W-1:0] meas_sum = I_ENC_POS + I_COMP_BACKLASH + I_COMP_LINEAR + I_COMP_HYST + I_COMP_MAP;
   wire logic q_coord = I_QUERY_IDX < mcd_pkg::QIDX_STRUT;
   wire logic q_strut = !q_coord && (I_QUERY_IDX < mcd_pkg::QIDX_END);
   wire logic [mcd_pkg::QIDX_W-1:0] q_sidx = I_QUERY_IDX - mcd_pkg::QIDX_STRUT;

   assign avg_bus.clear = start_ok;
   assign avg_bus.valid = I_SAMPLE;
   assign avg_bus.err_in = O_TRACKING_ERROR;
   assign avg_bus.vel_in = I_VELOCITY;
   assign avg_bus.span_log2 = span_mv;

   always_comb begin
      next_state = state;
      case (state)
         mcd_pkg::ST_READY: begin
            if (start_ok) begin
               next_state = mcd_pkg::ST_PROFILE;
            end
         end
         mcd_pkg::ST_PROFILE: begin
            if (prof_done) begin
               next_state = mcd_pkg::ST_READY;
            end else if (prof_fin) begin
               next_state = mcd_pkg::ST_SETTLE;
            end
         end
         mcd_pkg::ST_SETTLE: begin
            if (hold_done || tmo_hit) begin
               next_state = mcd_pkg::ST_READY;
            end
         end
         default: next_state = mcd_pkg::ST_READY;
      endcase
   end

   // ------------------------------------------------------------
   // control and events
   // ------------------------------------------------------------
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         state <= mcd_pkg::ST_READY;
         O_READY <= 1'b1;
         O_MOVE_REFUSED <= 1'b0;
         O_PROFILE_END <= 1'b0;
         O_MOTION_COMPLETE <= 1'b0;
         O_SETTLE_TIMEOUT <= 1'b0;
      end else begin
         state <= next_state;
         O_READY <= (next_state == mcd_pkg::ST_READY);
         O_MOVE_REFUSED <= start_bad;
         O_PROFILE_END <= prof_fin;
         O_MOTION_COMPLETE <= complete;
         O_SETTLE_TIMEOUT <= tmo_hit;
      end
   end

   // hold and timeout counters run only while settling
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST || start_ok || !is_settle) begin
         hold_cnt <= mcd_pkg::CNT_RST;
         tmo_cnt <= mcd_pkg::CNT_RST;
      end else begin
         hold_cnt <= win_ok ? hold_next : mcd_pkg::CNT_RST;
         tmo_cnt <= tmo_cnt + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // stored configuration and host parameters
   // ------------------------------------------------------------
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         method <= I_CFG_METHOD;
         pos_win <= I_CFG_POS_WIN;
         vel_win <= I_CFG_VEL_WIN;
         hold_lim <= I_CFG_HOLD;
         span <= clamp_span(I_CFG_SPAN);
         tmo_lim <= I_CFG_TIMEOUT;
      end else if (I_PARAM_WR) begin
         pos_win <= I_WR_POS_WIN;
         vel_win <= I_WR_VEL_WIN;
         hold_lim <= I_WR_HOLD;
         span <= clamp_span(I_WR_SPAN);
         tmo_lim <= I_WR_TIMEOUT;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         O_METHOD <= mcd_pkg::METHOD_PROFILER;
         O_PARAM_ACK <= 1'b0;
         O_PARAM_POS_WIN <= mcd_pkg::POS_RST;
         O_PARAM_VEL_WIN <= mcd_pkg::POS_RST;
         O_PARAM_HOLD <= mcd_pkg::CNT_RST;
         O_PARAM_SPAN <= '0;
         O_PARAM_TIMEOUT <= mcd_pkg::CNT_RST;
      end else begin
         O_METHOD <= method;
         O_PARAM_ACK <= I_PARAM_RD || I_PARAM_WR;
         if (I_PARAM_RD) begin
            O_PARAM_POS_WIN <= pos_win;
            O_PARAM_VEL_WIN <= vel_win;
            O_PARAM_HOLD <= hold_lim;
            O_PARAM_SPAN <= span;
            O_PARAM_TIMEOUT <= tmo_lim;
         end
      end
   end

   // ------------------------------------------------------------
   // profiler and position bookkeeping
   // ------------------------------------------------------------
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         O_DESTINATION_POS <= mcd_pkg::POS_RST;
         O_COMMANDED_POS <= mcd_pkg::POS_RST;
         step_mv <= mcd_pkg::POS_RST;
         span_mv <= '0;
      end else if (start_ok) begin
         O_DESTINATION_POS <= I_MOVE_TARGET;
         step_mv <= I_MOVE_STEP;
         span_mv <= span;
      end else if (is_prof && I_SAMPLE) begin
         if (last_step) begin
            O_COMMANDED_POS <= O_DESTINATION_POS;
         end else if (remaining[W-1]) begin
            O_COMMANDED_POS <= O_COMMANDED_POS - step_mv;
         end else begin
            O_COMMANDED_POS <= O_COMMANDED_POS + step_mv;
         end
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         O_MEASURED_POS <= mcd_pkg::POS_RST;
         O_TRACKING_ERROR <= mcd_pkg::POS_RST;
      end else begin
         O_MEASURED_POS <= meas_sum;
         O_TRACKING_ERROR <= O_MEASURED_POS - O_COMMANDED_POS;
      end
   end

   // ------------------------------------------------------------
   // position query
   // ------------------------------------------------------------
   always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
         O_QUERY_VALID <= 1'b0;
         O_QUERY_COUNT <= mcd_pkg::QCNT_NONE;
         O_QUERY_DATA <= '0;
      end else begin
         O_QUERY_VALID <= I_QUERY;
         if (I_QUERY && I_QUERY_ALL) begin
            O_QUERY_COUNT <= mcd_pkg::QCNT_ALL;
            O_QUERY_DATA <= I_PLAT_COORDS;
         end else if (I_QUERY && q_coord) begin
            O_QUERY_COUNT <= mcd_pkg::QCNT_ONE;
            O_QUERY_DATA <= QW'(pick(I_PLAT_COORDS, I_QUERY_IDX));
         end else if (I_QUERY && q_strut) begin
            O_QUERY_COUNT <= mcd_pkg::QCNT_ONE;
            O_QUERY_DATA <= QW'(pick(I_STRUT_LENS, q_sidx));
         end else if (I_QUERY) begin
            O_QUERY_COUNT <= mcd_pkg::QCNT_NONE;
            O_QUERY_DATA <= '0;
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------

   AST_REFUSE: assert property (
      I_MOVE_START && !(is_ready && I_GROUP_READY) |=> O_MOVE_REFUSED && $stable(O_DESTINATION_POS))
      else $error("move accepted while busy or group not ready");

   AST_PROF_DONE: assert property (
      O_PROFILE_END && O_METHOD == mcd_pkg::METHOD_PROFILER && $past(!I_RST, 2) |-> O_MOTION_COMPLETE)
      else $error("profiler method did not complete at profile end");

   AST_WIN_DONE: assert property (
      O_MOTION_COMPLETE && O_METHOD == mcd_pkg::METHOD_WINDOWED |-> $past(win_ok) && $past(is_settle))
      else $error("windowed completion without both means inside");

   AST_HOLD_RESTART: assert property (
      is_settle && !win_ok ##1 is_settle |-> hold_cnt == mcd_pkg::CNT_RST)
      else $error("hold count survived a window miss");

   AST_TIMEOUT: assert property (
      O_SETTLE_TIMEOUT |-> !O_MOTION_COMPLETE && $past(tmo_cnt) >= $past(tmo_lim) && O_READY)
      else $error("timeout raised early or with completion");

   AST_MEANS_ONLY: assert property (
      hold_done |-> avg_bus.full)
      else $error("settle accepted before the mean window filled");

   AST_MEAS: assert property (
      $past(!I_RST) |-> O_MEASURED_POS == $past(meas_sum))
      else $error("measured position is not encoder plus corrections");

   AST_TRACK: assert property (
      $past(!I_RST) |-> O_TRACKING_ERROR == $past(O_MEASURED_POS) - $past(O_COMMANDED_POS))
      else $error("tracking error is not measured minus commanded");

   AST_ARRIVE: assert property (
      O_PROFILE_END |-> O_COMMANDED_POS == O_DESTINATION_POS)
      else $error("profile ended away from destination");

   AST_CFG_HOLD: assert property (
      $past(!I_RST) |-> $stable(method))
      else $error("completion method changed without restart");

   AST_PARAM_WR: assert property (
      I_PARAM_WR |=> pos_win == $past(I_WR_POS_WIN) && O_PARAM_ACK)
      else $error("settle parameter write lost");

   AST_QUERY_ALL: assert property (
      I_QUERY && I_QUERY_ALL |=> O_QUERY_VALID && O_QUERY_COUNT == mcd_pkg::QCNT_ALL)
      else $error("platform query did not return six coordinates");
endmodule

/* sim/mcd_fb_model.sv */
// servo feedback model: sample strobe, encoder reading and velocity
`timescale 1ns/100ps
module mcd_fb_model (
   input wire logic i_clk,
   input wire logic signed [mcd_pkg::POS_W-1:0] i_cmd,
   input wire logic signed [mcd_pkg::POS_W-1:0] i_err,
   input wire logic signed [mcd_pkg::POS_W-1:0] i_vel,
   input wire logic signed [mcd_pkg::POS_W-1:0] i_comp_sum,
   output logic o_sample,
   output logic signed [mcd_pkg::POS_W-1:0] o_enc,
   output logic signed [mcd_pkg::POS_W-1:0] o_vel
);
   // one servo cycle every second clock; raw encoder chosen so that
   // the corrected position sits exactly i_err off the commanded one
   initial begin
      o_sample = 1'b0;
      o_enc = '0;
      o_vel = '0;
      forever begin
         @(negedge i_clk);
         o_sample <= ~o_sample;
         o_enc <= i_cmd + i_err - i_comp_sum;
         o_vel <= i_vel;
      end
   end
endmodule

/* sim/mcd_top_tb_top.sv */
// self-checking bench for the motion completion detector
`timescale 1ns/100ps
`define CHK(a, b) begin \
   checks_done++; \
   if ((a) !== (b)) begin \
      bad_count++; \
      $display("ERROR %0t: got %0h expected %0h", $time, a, b); \
   end \
end
module mcd_top_tb_top;
   localparam int W = mcd_pkg::POS_W;
   localparam int CW = mcd_pkg::N_COORD * W;
   localparam logic signed [W-1:0] ETAB [4] = '{32'shffff_fffd, 32'sh0000_0064, 32'shffff_ff9c, 32'sh0000_0000};
   localparam logic signed [W-1:0] VTAB [4] = '{32'shffff_fffd, 32'sh0000_0000, 32'sh0000_0000, 32'shffff_ff9c};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cfg_method = 1'b1;
   logic prd = 1'b0;
   logic pwr = 1'b0;
   logic grp_rdy = 1'b1;
   logic mv_start = 1'b0;
   logic query = 1'b0;
   logic q_all = 1'b0;
   logic [3:0] q_idx = 4'h0;
   logic [2:0] wr_span = 3'h0;
   logic [2:0] cfg_span = 3'h1;
   logic [W-1:0] wr_pos = '0, wr_vel = '0, wr_hold = '0, wr_tmo = '0;
   logic [W-1:0] cfg_pos = 32'h0000_000a, cfg_vel = 32'h0000_000a, cfg_hold = 32'h0000_0006, cfg_tmo = 32'h0000_0014;
   logic [W-1:0] step = 32'h0000_0004;
   logic signed [W-1:0] mv_tgt = '0, err = '0, vel = '0;
   logic signed [W-1:0] comp_b = 32'sh0000_0011, comp_l = 32'sh0000_0022;
   logic signed [W-1:0] comp_h = 32'shffff_fff0, comp_m = 32'sh0000_0005;
   wire logic signed [W-1:0] comp_sum = comp_b + comp_l + comp_h + comp_m;
   logic [CW-1:0] coords, struts, o_qdata;
   logic sample, o_method, o_ready, o_refused, o_pe, o_mc, o_to, o_ack, o_qv;
   logic signed [W-1:0] enc, fb_vel, o_meas, o_cmd, o_trk, o_dest;
   logic [W-1:0] o_ppos, o_pvel, o_phold, o_ptmo;
   logic [2:0] o_pspan, o_qcnt;
   int bad_count = 0, checks_done = 0, cyc = 0, n_pe, n_mc, n_to, pe_cyc, mc_cyc, to_cyc;

   mcd_top #(.LMAX(2)) mcd_top_i (
      .I_REF_CLK(clk), .I_RST(rst), .I_CFG_METHOD(cfg_method), .I_CFG_POS_WIN(cfg_pos), .I_CFG_VEL_WIN(cfg_vel),
      .I_CFG_HOLD(cfg_hold), .I_CFG_SPAN(cfg_span), .I_CFG_TIMEOUT(cfg_tmo), .I_PARAM_RD(prd), .I_PARAM_WR(pwr),
      .I_WR_POS_WIN(wr_pos), .I_WR_VEL_WIN(wr_vel), .I_WR_HOLD(wr_hold), .I_WR_SPAN(wr_span), .I_WR_TIMEOUT(wr_tmo),
      .I_GROUP_READY(grp_rdy), .I_MOVE_START(mv_start), .I_MOVE_TARGET(mv_tgt), .I_MOVE_STEP(step),
      .I_SAMPLE(sample), .I_ENC_POS(enc), .I_COMP_BACKLASH(comp_b), .I_COMP_LINEAR(comp_l), .I_COMP_HYST(comp_h),
      .I_COMP_MAP(comp_m), .I_VELOCITY(fb_vel), .I_QUERY(query), .I_QUERY_ALL(q_all), .I_QUERY_IDX(q_idx),
      .I_PLAT_COORDS(coords), .I_STRUT_LENS(struts), .O_METHOD(o_method), .O_READY(o_ready),
      .O_MOVE_REFUSED(o_refused), .O_PROFILE_END(o_pe), .O_MOTION_COMPLETE(o_mc), .O_SETTLE_TIMEOUT(o_to),
      .O_MEASURED_POS(o_meas), .O_COMMANDED_POS(o_cmd), .O_TRACKING_ERROR(o_trk), .O_DESTINATION_POS(o_dest),
      .O_PARAM_ACK(o_ack), .O_PARAM_POS_WIN(o_ppos), .O_PARAM_VEL_WIN(o_pvel), .O_PARAM_HOLD(o_phold),
      .O_PARAM_SPAN(o_pspan), .O_PARAM_TIMEOUT(o_ptmo), .O_QUERY_VALID(o_qv), .O_QUERY_COUNT(o_qcnt),
      .O_QUERY_DATA(o_qdata)
   );
   mcd_fb_model mcd_fb_model_i (.i_clk(clk), .i_cmd(o_cmd), .i_err(err), .i_vel(vel), .i_comp_sum(comp_sum),
      .o_sample(sample), .o_enc(enc), .o_vel(fb_vel));

   always #2.5 clk = ~clk;

   // event log: cycle of each profile end, completion and timeout pulse
   always @(negedge clk) begin
      cyc++;
      if (o_pe === 1'b1) begin
         n_pe++;
         pe_cyc = cyc;
      end
      if (o_mc === 1'b1) begin
         n_mc++;
         mc_cyc = cyc;
      end
      if (o_to === 1'b1) begin
         n_to++;
         to_cyc = cyc;
      end
   end

   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic end_test(input string s);
      $display("test %s finished", s);
   endtask

   task automatic do_reset(input logic m);
      rst = 1'b1;
      cfg_method = m;
      tick(2);
      `CHK({o_ready, o_method, o_pe, o_mc, o_ppos}, {1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_0000})
      rst = 1'b0;
      tick(1);
      `CHK(o_method, m)
   endtask

   task automatic prm(input logic rd, input logic [W-1:0] pw, vw, hd, input logic [2:0] sp, input logic [W-1:0] tm);
      {wr_pos, wr_vel, wr_hold, wr_span, wr_tmo} = {pw, vw, hd, sp, tm};
      prd = rd;
      pwr = !rd;
      tick(1);
      prd = 1'b0;
      pwr = 1'b0;
      `CHK(o_ack, 1'b1)
      if (rd)
         `CHK({o_ppos, o_pvel, o_phold, o_pspan, o_ptmo}, {pw, vw, hd, sp, tm})
      tick(1);
   endtask

   task automatic qry(input logic all, input logic [3:0] idx, input logic [2:0] n, input logic [CW-1:0] d);
      query = 1'b1;
      q_all = all;
      q_idx = idx;
      tick(1);
      query = 1'b0;
      `CHK({o_qv, o_qcnt, o_qdata}, {1'b1, n, d})
      tick(1);
   endtask

   task automatic move(input logic signed [W-1:0] t, input bit poke, input bit ok, input int lo, input int hi);
      int n;
      n = 0;
      n_pe = 0;
      n_mc = 0;
      n_to = 0;
      mv_tgt = t;
      mv_start = 1'b1;
      tick(1);
      mv_start = 1'b0;
      `CHK({o_ready, o_dest}, {1'b0, t})
      if (poke) begin
         tick(1);
         mv_tgt = 32'sh0000_0777;
         mv_start = 1'b1;
         tick(1);
         mv_start = 1'b0;
         `CHK({o_refused, o_ready, o_dest}, {1'b1, 1'b0, t})
      end
      while (o_ready !== 1'b1 && n < 500) begin
         tick(1);
         n++;
      end
      // tracking error trails the last profiler step by two clocks
      tick(2);
      `CHK(n_pe, 1)
      `CHK(n_mc + 2 * n_to, ok ? 1 : 2)
      `CHK((ok ? mc_cyc : to_cyc) - pe_cyc inside {[lo:hi]}, 1'b1)
      `CHK({o_ready, o_cmd, o_meas, o_trk}, {1'b1, t, t + err, err})
   endtask

   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      for (int k = 0; k < 6; k++) begin
         coords[k*W +: W] = 32'h1000_0000 + k;
         struts[k*W +: W] = 32'h2000_0000 + k;
      end
      do_reset(1'b1);
      cfg_method = 1'b0;
      tick(3);
      `CHK(o_method, 1'b1)
      prm(1'b1, 32'h0000_000a, 32'h0000_000a, 32'h0000_0006, 3'h1, 32'h0000_0014);
      prm(1'b0, 32'h0000_000c, 32'h0000_000c, 32'h0000_0005, 3'h1, 32'h0000_001e);
      prm(1'b1, 32'h0000_000c, 32'h0000_000c, 32'h0000_0005, 3'h1, 32'h0000_001e);
      end_test("params");
      grp_rdy = 1'b0;
      mv_start = 1'b1;
      tick(1);
      mv_start = 1'b0;
      `CHK({o_refused, o_ready}, 2'h3)
      grp_rdy = 1'b1;
      tick(1);
      end_test("refuse");
      // first case settles, the others break the position or velocity window
      for (int i = 0; i < 4; i++) begin
         err = ETAB[i];
         vel = VTAB[i];
         move(i[0] ? 32'sh0000_0000 : 32'sh0000_0028, i == 1, i == 0, i == 0 ? 5 : 30, i == 0 ? 14 : 32);
      end
      end_test("windowed");
      do_reset(1'b0);
      err = 32'sh0000_0064;
      move(32'sh0000_0028, 1'b0, 1'b1, 0, 0);
      end_test("profiler");
      for (int k = 0; k < 12; k++)
         qry(1'b0, k[3:0], 3'h1, {160'h0, k < 6 ? coords[k*W +: W] : struts[(k-6)*W +: W]});
      qry(1'b1, 4'h0, 3'h6, coords);
      qry(1'b0, 4'hc, 3'h0, '0);
      end_test("query");
      wrap_up();
   end

   initial begin
      #50000;
      bad_count++;
      $display("ERROR %0t: watchdog expired", $time);
      wrap_up();
   end
endmodule
